/* core/din_cond_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// digital input conditioning unit.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef DIN_COND_REGS_SVH
`define DIN_COND_REGS_SVH

`define DIN_NUM_INPUTS 5
`define DIN_ADDR_W 8

`define DIN_CLK_PERIOD_NS 25
`define DIN_SAMPLE_PERIOD_NS 1000000
`define DIN_SAMPLE_CYCLES (`DIN_SAMPLE_PERIOD_NS / `DIN_CLK_PERIOD_NS)

`define DIN_OFS_SPECIAL_FUNCTION_ENABLE 8'h00
`define DIN_OFS_INPUT_INVERSION 8'h04
`define DIN_OFS_INPUT_FORCE_ENABLE 8'h08
`define DIN_OFS_INPUT_FORCE_VALUE 8'h0C
`define DIN_OFS_INPUT_RAW_LEVEL 8'h10
`define DIN_OFS_INPUT_THRESHOLD_SELECT 8'h14
`define DIN_OFS_INPUT_ROUTING_ENABLE 8'h18
`define DIN_OFS_INPUT_SUMMARY_WORD 8'h1C
`define DIN_OFS_MODE_CONTROL 8'h20
`define DIN_OFS_INTERLOCK_STATUS 8'h24
`define DIN_OFS_ROUTE_BASE 8'h80

`define DIN_SFE_NEG_LIMIT 0
`define DIN_SFE_POS_LIMIT 1
`define DIN_SFE_HOME 2
`define DIN_SFE_INTERLOCK 3
`define DIN_SFE_W 4
`define DIN_LEVEL_BASE 16
`define DIN_MODE_CLKDIR_BIT 0
`define DIN_ILK_FAULT_BIT 0
`define DIN_ILK_RELEASE_BIT 1

`define DIN_ROUTE_ENTRIES 32
`define DIN_ROUTE_W 8
`define DIN_ROUTE_INV_BIT 7
`define DIN_ROUTE_SRC_ZERO 7'h00
`define DIN_ROUTE_SRC_INPUT_LAST 7'h10

`define DIN_RESET_CTRL 5'h00
`define DIN_RESET_SFE 4'h0
`define DIN_RESET_ROUTE 8'h00

`endif

/* core/din_cond_pkg.sv */
// Types of the digital input conditioning unit.
// Mode codes and the 8-bit route code width are written here; other constants are in din_cond_regs.svh.
package din_cond_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b01,
    MODE_ROUTING = 2'b10
  } proc_mode_e;

  typedef logic [7:0] route_code_t;

endpackage

/* core/digital_input_conditioning.sv */
// Digital input conditioning: pin synchronisation, 1 ms sampling, forcing,
// inversion, special functions, input routing and the summary word.
// Assumes asynchronous switch pins and a plain register port on mclk_i.
`include "din_cond_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module digital_input_conditioning #(
  parameter int unsigned SAMPLE_CYCLES = `DIN_SAMPLE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [`DIN_NUM_INPUTS-1:0] din_i,
  input wire logic [`DIN_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [31:0] summary_o,
  output logic [`DIN_NUM_INPUTS-1:0] thr_sel_o,
  output logic clk_dir_mode_o,
  output logic interlock_fault_o,
  output logic motion_release_o
);

  localparam int N = `DIN_NUM_INPUTS;
  localparam int RE = `DIN_ROUTE_ENTRIES;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] sync3_r;
  logic [N-1:0] stable_r;
  logic [15:0] tick_cnt_r;
  logic tick_r;
  logic [N-1:0] raw_r;
  logic [`DIN_SFE_W-1:0] sfe_r;
  logic [N-1:0] inv_r;
  logic [N-1:0] force_en_r;
  logic [N-1:0] force_val_r;
  logic [N-1:0] thr_r;
  logic clk_dir_r;
  din_cond_pkg::proc_mode_e mode_r;
  din_cond_pkg::route_code_t route_r [RE];
  logic [31:0] summary_r;
  logic [31:0] summary_nxt;
  logic [N-1:0] forced;
  logic [N-1:0] level;
  logic [N-1:0] inv_eff;
  logic [31:0] normal_word;
  logic [31:0] routed_word;
  logic fault_r;
  logic release_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic route_hit;
  logic [4:0] route_idx;
  logic wr_route_en;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: a change counts once the second and third stage agree.

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sync1_r <= `DIN_RESET_CTRL;
      sync2_r <= `DIN_RESET_CTRL;
      sync3_r <= `DIN_RESET_CTRL;
    end
    else
    begin
      sync1_r <= din_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      stable_r <= `DIN_RESET_CTRL;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (sync2_r[i] == sync3_r[i])
        begin
          stable_r[i] <= sync3_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider and sampling.

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == 16'(SAMPLE_CYCLES - 1))
    begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      raw_r <= `DIN_RESET_CTRL;
    end
    else if (tick_r)
    begin
      raw_r <= stable_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  assign wr_route_en = wr_i && (addr_i == `DIN_OFS_INPUT_ROUTING_ENABLE);

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sfe_r <= `DIN_RESET_SFE;
      inv_r <= `DIN_RESET_CTRL;
      force_en_r <= `DIN_RESET_CTRL;
      force_val_r <= `DIN_RESET_CTRL;
      thr_r <= `DIN_RESET_CTRL;
      clk_dir_r <= 1'b0;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        `DIN_OFS_SPECIAL_FUNCTION_ENABLE: sfe_r <= wdata_i[`DIN_SFE_W-1:0];
        `DIN_OFS_INPUT_INVERSION: inv_r <= wdata_i[N-1:0];
        `DIN_OFS_INPUT_FORCE_ENABLE: force_en_r <= wdata_i[N-1:0];
        `DIN_OFS_INPUT_FORCE_VALUE: force_val_r <= wdata_i[N-1:0];
        `DIN_OFS_INPUT_THRESHOLD_SELECT: thr_r <= wdata_i[N-1:0];
        `DIN_OFS_MODE_CONTROL: clk_dir_r <= wdata_i[`DIN_MODE_CLKDIR_BIT];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      mode_r <= din_cond_pkg::MODE_NORMAL;
    end
    else if (wr_route_en)
    begin
      mode_r <= wdata_i[0] ? din_cond_pkg::MODE_ROUTING
                           : din_cond_pkg::MODE_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing table with preload on entry into routing mode.

  assign route_hit = addr_i >= `DIN_OFS_ROUTE_BASE;
  assign route_idx = addr_i[6:2];

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      for (int k = 0; k < RE; k++)
      begin
        route_r[k] <= `DIN_RESET_ROUTE;
      end
    end
    else if (wr_route_en && wdata_i[0] && mode_r == din_cond_pkg::MODE_NORMAL)
    begin
      for (int k = 0; k < RE; k++)
      begin
        route_r[k] <= `DIN_RESET_ROUTE;
      end
      for (int i = 0; i < N; i++)
      begin
        route_r[`DIN_LEVEL_BASE + i] <= {inv_eff[i], 7'(i + 1)};
      end
      for (int i = 0; i < 3; i++)
      begin
        if (sfe_r[i])
        begin
          route_r[i] <= {inv_eff[i], 7'(i + 1)};
        end
      end
    end
    else if (wr_i && route_hit)
    begin
      route_r[route_idx] <= wdata_i[`DIN_ROUTE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Normal processing: force, invert, then level and special bits.

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      forced[i] = force_en_r[i] ? force_val_r[i] : raw_r[i];
      inv_eff[i] = inv_r[i] && !(clk_dir_r && i < 2);
      level[i] = forced[i] ^ inv_eff[i];
    end
  end

  always_comb
  begin
    normal_word = 32'h0000_0000;
    normal_word[`DIN_LEVEL_BASE +: N] = level;
    if (!clk_dir_r)
    begin
      normal_word[`DIN_SFE_NEG_LIMIT] = sfe_r[`DIN_SFE_NEG_LIMIT] && level[0];
      normal_word[`DIN_SFE_POS_LIMIT] = sfe_r[`DIN_SFE_POS_LIMIT] && level[1];
    end
    normal_word[`DIN_SFE_HOME] = sfe_r[`DIN_SFE_HOME] && level[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routed processing: each summary bit follows its table entry.

  always_comb
  begin
    logic [6:0] src;
    logic val;
    src = 7'h00;
    val = 1'b0;
    routed_word = 32'h0000_0000;
    for (int k = 0; k < RE; k++)
    begin
      src = route_r[k][6:0];
      val = 1'b0;
      for (int i = 0; i < N; i++)
      begin
        if (src == 7'(i + 1))
        begin
          val = raw_r[i];
        end
      end
      routed_word[k] = val ^ route_r[k][`DIN_ROUTE_INV_BIT];
    end
  end

  always_comb
  begin
    unique case (mode_r)
      din_cond_pkg::MODE_ROUTING: summary_nxt = routed_word;
      din_cond_pkg::MODE_NORMAL: summary_nxt = normal_word;
      default: summary_nxt = normal_word;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      summary_r <= 32'h0000_0000;
    end
    else if (tick_r)
    begin
      summary_r <= summary_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interlock release.

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      fault_r <= 1'b0;
      release_r <= 1'b0;
    end
    else
    begin
      fault_r <= sfe_r[`DIN_SFE_INTERLOCK] && !summary_r[`DIN_SFE_INTERLOCK];
      release_r <= !sfe_r[`DIN_SFE_INTERLOCK] || summary_r[`DIN_SFE_INTERLOCK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (route_hit)
    begin
      rdata_nxt[`DIN_ROUTE_W-1:0] = route_r[route_idx];
    end
    else
    begin
      unique case (addr_i)
        `DIN_OFS_SPECIAL_FUNCTION_ENABLE: rdata_nxt[`DIN_SFE_W-1:0] = sfe_r;
        `DIN_OFS_INPUT_INVERSION: rdata_nxt[N-1:0] = inv_r;
        `DIN_OFS_INPUT_FORCE_ENABLE: rdata_nxt[N-1:0] = force_en_r;
        `DIN_OFS_INPUT_FORCE_VALUE: rdata_nxt[N-1:0] = force_val_r;
        `DIN_OFS_INPUT_RAW_LEVEL: rdata_nxt[N-1:0] = raw_r;
        `DIN_OFS_INPUT_THRESHOLD_SELECT: rdata_nxt[N-1:0] = thr_r;
        `DIN_OFS_INPUT_ROUTING_ENABLE:
          rdata_nxt[0] = (mode_r == din_cond_pkg::MODE_ROUTING);
        `DIN_OFS_INPUT_SUMMARY_WORD: rdata_nxt = summary_r;
        `DIN_OFS_MODE_CONTROL: rdata_nxt[`DIN_MODE_CLKDIR_BIT] = clk_dir_r;
        `DIN_OFS_INTERLOCK_STATUS:
        begin
          rdata_nxt[`DIN_ILK_FAULT_BIT] = fault_r;
          rdata_nxt[`DIN_ILK_RELEASE_BIT] = release_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      rdata_r <= rdata_nxt;
    end
    else
    begin
      rdata_r <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign rdata_o = rdata_r;
  assign summary_o = summary_r;
  assign thr_sel_o = thr_r;
  assign clk_dir_mode_o = clk_dir_r;
  assign interlock_fault_o = fault_r;
  assign motion_release_o = release_r;

endmodule

`default_nettype wire

/* bench/din_cond_asserts.sv */
// Checker on the ports of the input conditioning unit.
// Assumes one clock mclk_i and the synchronous reset_i.
`include "din_cond_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module din_cond_asserts #(
  parameter int unsigned SAMPLE_CYCLES = 20
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [31:0] summary_o,
  input wire logic [4:0] thr_sel_o,
  input wire logic interlock_fault_o,
  input wire logic motion_release_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  int unsigned gap_r;
  // Counts cycles since the summary word last changed.
  always_ff @(posedge mclk_i)
    if (reset_i)
      gap_r <= SAMPLE_CYCLES;
    else if ($changed(summary_o))
      gap_r <= 1;
    else
      gap_r <= gap_r + 1;
  a_summary_tick_gap: assert property ($changed(summary_o) |-> gap_r >= SAMPLE_CYCLES)
    else $error("summary changed between ticks");
  a_thr_follow: assert property (wr_i && addr_i == `DIN_OFS_INPUT_THRESHOLD_SELECT |=>
    {27'h0, thr_sel_o} == ($past(wdata_i) & 32'h1F)) else $error("threshold write lost");
  a_thr_readback: assert property (rd_i && addr_i == `DIN_OFS_INPUT_THRESHOLD_SELECT |=>
    rdata_o == {27'h0, thr_sel_o}) else $error("threshold read wrong");
  logic spare_used_r;
  // Set once a routing entry of summary bits 4 to 15 is written with a code other than zero.
  always_ff @(posedge mclk_i)
    if (reset_i)
      spare_used_r <= 1'b0;
    else if (wr_i && addr_i >= 8'h90 && addr_i <= 8'hBF && wdata_i[7:0] != 8'h00)
      spare_used_r <= 1'b1;
  a_spare_bits_zero: assert property (!spare_used_r |-> summary_o[15:4] == 12'h000)
    else $error("spare special bits set");
  a_ilk_fault_cause: assert property (interlock_fault_o |-> !$past(summary_o[3]))
    else $error("fault without low interlock bit");
  a_ilk_hold_cause: assert property (!motion_release_o |-> !$past(summary_o[3]))
    else $error("motion held with interlock bit high");
  a_ilk_exclusive: assert property (!(interlock_fault_o && motion_release_o))
    else $error("fault and release together");
  a_ilk_recover: assert property ($fell(interlock_fault_o) |-> motion_release_o)
    else $error("no release after fault cleared");
endmodule
bind digital_input_conditioning din_cond_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (
  .mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .summary_o, .thr_sel_o,
  .interlock_fault_o, .motion_release_o);
`default_nettype wire

/* bench/switch_bank.sv */
// Model of the switches wired to the five input pins.
// Assumes the bench sets wanted levels on the unit clock.
`timescale 1ns/100ps
`default_nettype none
module switch_bank (
  input wire logic clk_i,
  input wire logic [4:0] level_i,
  input wire logic [3:0] settle_i,
  output var logic [4:0] pin_o
);
  logic [3:0] cnt_r = 4'h0;
  initial pin_o = 5'h00;
  // A contact reaches its new level only after its settling time.
  always @(posedge clk_i)
    if (level_i == pin_o)
      cnt_r <= 4'h0;
    else if (cnt_r >= settle_i)
      pin_o <= level_i;
    else
      cnt_r <= cnt_r + 4'h1;
endmodule
`default_nettype wire

/* bench/tb_digital_input_conditioning.sv */
// Self-checking bench of the digital input conditioning unit.
// Assumes the switch model on the pins and a 20-cycle sample tick.
`timescale 1ns/100ps
`default_nettype none
module tb_digital_input_conditioning;
  localparam int S = 20;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [4:0] din_i;
  logic [4:0] want = 5'h00;
  logic [3:0] settle = 4'h0;
  logic [31:0] rdata_o;
  logic [31:0] summary_o;
  logic [4:0] thr_sel_o;
  logic clk_dir_mode_o;
  logic interlock_fault_o;
  logic motion_release_o;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000_06DF;
  int m [64] = '{default: 0};
  int codes [5] = '{8'h00, 8'h80, 8'h04, 8'h84, 8'h41};
  logic [31:0] q;
  logic [31:0] e;
  digital_input_conditioning #(.SAMPLE_CYCLES(S)) dut (.mclk_i, .reset_i, .din_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .summary_o, .thr_sel_o, .clk_dir_mode_o,
    .interlock_fault_o, .motion_release_o);
  switch_bank sw (.clk_i(mclk_i), .level_i(want), .settle_i(settle), .pin_o(din_i));
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] model();
    logic [31:0] s;
    int c;
    logic v;
    s = 32'h0;
    for (int k = 0; k < 32; k++)
    begin
      c = m[32 + k] & 127;
      v = (c >= 1 && c <= 5) ? want[c - 1] : 1'b0;
      s[k] = m[6][0] & (v ^ m[32 + k][7]);
    end
    for (int n = 0; n < 5 && !m[6][0]; n++)
    begin
      v = m[2][n] ? m[3][n] : want[n];
      v ^= m[1][n] & !(m[8][0] && n < 2);
      s[16 + n] = v;
      if (n < 3) s[n] = v & m[0][n] & !(m[8][0] && n < 2);
    end
    return s;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    // Read data stand for the one cycle after the strobe; take them at its closing edge.
    @(posedge mclk_i);
    d = rdata_o;
  endtask
  task automatic set(input logic [7:0] a, input int d);
    if (a == 8'h18 && d[0] && !m[6][0])
    begin
      for (int k = 0; k < 32; k++) m[32 + k] = 0;
      for (int n = 0; n < 5; n++)
      begin
        m[48 + n] = m[1][n] * 128 + n + 1;
        if (n < 3) m[32 + n] = m[0][n] ? m[48 + n] : 0;
      end
    end
    m[a >> 2] = d;
    bus_w(a, d);
  endtask
  task automatic tk();
    repeat (4 * S) @(posedge mclk_i);
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    chk({clk_dir_mode_o, thr_sel_o}, 0);
    for (int k = 0; k < 11; k++)
    begin
      rd(8'(k * 4), q);
      chk(q, k == 9 ? 2 : 0);
    end
    bus_w(8'h10, 32'h1F);
    bus_w(8'h40, 32'hFF);
    rd(8'h40, q);
    chk(q, 0);
    for (int i = 0; i < 8; i++)
    begin
      want <= 5'(xs());
      settle <= 4'(xs());
      for (int k = 0; k < 4; k++) set(8'(k * 4), xs() & (k ? 31 : 15));
      set(8'h14, xs() & 31);
      set(8'h20, i > 5);
      tk();
      chk(summary_o, model());
      chk({interlock_fault_o, motion_release_o}, {m[0][3], !m[0][3]});
      chk(thr_sel_o, m[5]);
      chk(clk_dir_mode_o, m[8]);
      rd(8'h10, q);
      chk(q, want);
    end
    set(8'h08, 0);
    set(8'h00, 7);
    set(8'h20, 0);
    tk();
    q = summary_o;
    set(8'h18, 1);
    tk();
    chk(summary_o, q);
    chk(summary_o, model());
    set(8'h04, xs() & 31);
    set(8'h08, 31);
    tk();
    chk(summary_o, model());
    set(8'h00, 15);
    foreach (codes[j])
    begin
      set(8'h8C, codes[j]);
      tk();
      e = model();
      chk(summary_o, e);
      chk(interlock_fault_o, !e[3]);
      rd(8'h8C, q);
      chk(q, codes[j]);
    end
    set(8'h18, 0);
    tk();
    chk(summary_o, model());
    end_of_test();
  end
endmodule
`default_nettype wire
